// file: power_down_mode_controller.sv
// Power-down mode controller: mode selection on sleep, clock gating, wake wait, prescaler.
// Assumes a plain register port, a one-cycle sleep pulse and a wake pulse from the interrupt logic.
// Function
// [RULE1] Eight modes after reset: active high speed plus seven reduced-power modes.
// [RULE2] Active medium speed runs CPU and peripherals on osc divided 8/16/32/64.
// [RULE3] Sleep modes halt CPU; peripherals run on system clock, medium variant divided.
// [RULE4] Subactive runs CPU and peripherals on subclock divided 2, 4 or 8.
// [RULE5] Subsleep and watch halt CPU; peripherals on subclock, subsleep divided.
// [RULE6] Standby stops CPU and all peripheral clocks.
// [RULE7] Each unused peripheral can be halted individually in any mode.
// [RULE8] Deep stop bit 7 selects sleep/subsleep when 0, standby/watch when 1.
// [RULE9] Wait-select bits 6..4 set the hold after interrupt exit to active or sleep.
// [RULE10] Software sets wait at least oscillator settling; external clock uses code 101.
// [RULE11] Software lengthens the wait if operation is unstable after wake.
// [RULE12] Bit 3 selects system clock or subclock for CPU when watch mode ends.
// [RULE13] Bit 2 with other bits and flags chooses the mode after sleep.
// [RULE14] Bits 1..0, reset 11, select medium division; written only in active high or subactive.
// [RULE15] Wait codes: 8192,16384,1024,2048,4096,2,8,16 states.
// [RULE16] Software picks the external-clock code only when an external clock is used.
// [RULE17] Prescaler stops and clears in standby, watch, subactive and subsleep.
// [RULE18] After reset the block starts in active high speed, undivided clock.
// [RULE19] Wake wait counts system clock states from oscillator restart, then releases clocks.
`timescale 1ns/100ps
`include "pdm_defines.svh"
module power_down_mode_controller (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        sleep_req,
   input  wire logic        wake_irq,
   input  wire logic        sub_tick,
   output logic             cpu_clk_en,
   output logic      [7:0]  periph_clk_en,
   output logic             osc_run,
   output logic      [12:0] prescale_out,
   output logic      [7:0]  mode_out
);
   pdm_pkg::mode_t mode_ff;
   pdm_pkg::mode_t nxt_mode;
   pdm_pkg::mode_t wake_mode_ff;
   logic [7:0]     ctrl_one_ff;
   logic [7:0]     ctrl_two_ff;
   logic [7:0]     halt_ff;
   logic [7:0]     rdata_ff;
   logic           waiting_ff;
   logic [14:0]    wait_cnt_ff;
   logic [14:0]    wait_len;
   logic [12:0]    prescale_ff;
   logic           cpu_run;
   logic           periph_run;
   logic           stopped_osc;
   logic           mode_ok_for_div;
   logic [7:0]     halt_mask;

   clk_gate_if gi ();

   clk_divider u_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (periph_run),
      .gi      (gi)
   );

   // Medium division only writable in active high speed or subactive
   assign mode_ok_for_div = (mode_ff == pdm_pkg::MODE_ACTIVE_HIGH) || (mode_ff == pdm_pkg::MODE_SUBACTIVE);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_one_ff <= `PDM_CTRL_ONE_RESET;
      end else if (reg_wr && reg_addr == `PDM_ADDR_CTRL_ONE) begin
         ctrl_one_ff[7:2] <= reg_wdata[7:2];
         if (mode_ok_for_div) begin
            ctrl_one_ff[1:0] <= reg_wdata[1:0]; // see [RULE14]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_two_ff <= `PDM_CTRL_TWO_RESET;
      end else if (reg_wr && reg_addr == `PDM_ADDR_CTRL_TWO) begin
         ctrl_two_ff <= {6'h00, reg_wdata[1:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         halt_ff <= `PDM_HALT_RESET;
      end else if (reg_wr && reg_addr == `PDM_ADDR_HALT) begin
         halt_ff <= reg_wdata; // see [RULE7]
      end
   end

   // Mode chosen on the sleep instruction or the wake interrupt
   always_comb begin
      nxt_mode = mode_ff;
      if (sleep_req && !waiting_ff) begin
         unique case (mode_ff)
            pdm_pkg::MODE_ACTIVE_HIGH, pdm_pkg::MODE_ACTIVE_MED, pdm_pkg::MODE_SUBACTIVE: begin
               if (ctrl_one_ff[`PDM_BIT_DEEP_STOP]) begin // see [RULE8]
                  if (ctrl_one_ff[`PDM_BIT_SLEEP_TARGET]) begin // see [RULE13]
                     nxt_mode = pdm_pkg::MODE_WATCH;
                  end else if (ctrl_two_ff[`PDM_BIT_DIRECT_XFER]) begin
                     if (ctrl_one_ff[`PDM_BIT_SLOW_ON_WAKE]) begin
                        nxt_mode = pdm_pkg::MODE_SUBACTIVE;
                     end else if (ctrl_two_ff[`PDM_BIT_MEDIUM_SPEED]) begin
                        nxt_mode = pdm_pkg::MODE_ACTIVE_MED;
                     end else begin
                        nxt_mode = pdm_pkg::MODE_ACTIVE_HIGH;
                     end
                  end else begin
                     nxt_mode = pdm_pkg::MODE_STANDBY;
                  end
               end else if (ctrl_one_ff[`PDM_BIT_SLOW_ON_WAKE]) begin
                  nxt_mode = pdm_pkg::MODE_SUBSLEEP;
               end else if (ctrl_two_ff[`PDM_BIT_MEDIUM_SPEED]) begin
                  nxt_mode = pdm_pkg::MODE_SLEEP_MED;
               end else begin
                  nxt_mode = pdm_pkg::MODE_SLEEP_HIGH;
               end
            end
            default: nxt_mode = mode_ff;
         endcase
      end else if (wake_irq && !waiting_ff) begin
         unique case (mode_ff)
            pdm_pkg::MODE_SLEEP_HIGH: nxt_mode = pdm_pkg::MODE_ACTIVE_HIGH;
            pdm_pkg::MODE_SLEEP_MED:  nxt_mode = pdm_pkg::MODE_ACTIVE_MED;
            pdm_pkg::MODE_SUBSLEEP:   nxt_mode = pdm_pkg::MODE_SUBACTIVE;
            pdm_pkg::MODE_WATCH, pdm_pkg::MODE_STANDBY: begin
               if (ctrl_one_ff[`PDM_BIT_SLOW_ON_WAKE]) begin // see [RULE12]
                  nxt_mode = pdm_pkg::MODE_SUBACTIVE;
               end else if (ctrl_two_ff[`PDM_BIT_MEDIUM_SPEED]) begin
                  nxt_mode = pdm_pkg::MODE_ACTIVE_MED;
               end else begin
                  nxt_mode = pdm_pkg::MODE_ACTIVE_HIGH;
               end
            end
            default: nxt_mode = mode_ff;
         endcase
      end
   end

   // Leaving a mode with the oscillator halted for a system-clock mode needs the wait
   assign stopped_osc = (mode_ff == pdm_pkg::MODE_STANDBY) || (mode_ff == pdm_pkg::MODE_WATCH) ||
                        (mode_ff == pdm_pkg::MODE_SUBACTIVE) || (mode_ff == pdm_pkg::MODE_SUBSLEEP);

   always_comb begin
      unique case (ctrl_one_ff[`PDM_BIT_WAIT_HI:`PDM_BIT_WAIT_LO]) // see [RULE15]
         3'b000: wait_len = `PDM_WAIT_000;
         3'b001: wait_len = `PDM_WAIT_001;
         3'b010: wait_len = `PDM_WAIT_010;
         3'b011: wait_len = `PDM_WAIT_011;
         3'b100: wait_len = `PDM_WAIT_100;
         3'b101: wait_len = `PDM_WAIT_101;
         3'b110: wait_len = `PDM_WAIT_110;
         default: wait_len = `PDM_WAIT_111;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= pdm_pkg::MODE_ACTIVE_HIGH; // see [RULE18]
      end else if (waiting_ff) begin
         if (wait_cnt_ff == 15'h0001) begin
            mode_ff <= wake_mode_ff; // see [RULE19]
         end
      end else if (nxt_mode != mode_ff && stopped_osc && nxt_mode != pdm_pkg::MODE_SUBACTIVE &&
                   nxt_mode != pdm_pkg::MODE_SUBSLEEP && nxt_mode != pdm_pkg::MODE_WATCH &&
                   nxt_mode != pdm_pkg::MODE_STANDBY) begin
         mode_ff <= mode_ff;
      end else begin
         mode_ff <= nxt_mode; // see [RULE1]
      end
   end

   // Wake wait: CPU and peripherals held until the selected number of states elapses
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waiting_ff   <= 1'b0;
         wait_cnt_ff  <= 15'h0000;
         wake_mode_ff <= pdm_pkg::MODE_ACTIVE_HIGH;
      end else if (waiting_ff) begin
         wait_cnt_ff <= wait_cnt_ff - 15'h0001;
         if (wait_cnt_ff == 15'h0001) begin
            waiting_ff <= 1'b0;
         end
      end else if (nxt_mode != mode_ff && stopped_osc && nxt_mode != pdm_pkg::MODE_SUBACTIVE &&
                   nxt_mode != pdm_pkg::MODE_SUBSLEEP && nxt_mode != pdm_pkg::MODE_WATCH &&
                   nxt_mode != pdm_pkg::MODE_STANDBY) begin
         waiting_ff   <= 1'b1; // see [RULE9]
         wait_cnt_ff  <= wait_len;
         wake_mode_ff <= nxt_mode;
      end
   end

   // Clock routing per mode
   always_comb begin
      cpu_run        = 1'b0;
      periph_run     = 1'b0;
      gi.use_sub     = 1'b0;
      gi.sys_divided = 1'b0;
      gi.sub_divided = 1'b0;
      unique case (mode_ff)
         pdm_pkg::MODE_ACTIVE_HIGH: begin
            cpu_run    = 1'b1;
            periph_run = 1'b1;
         end
         pdm_pkg::MODE_ACTIVE_MED: begin
            cpu_run        = 1'b1; // see [RULE2]
            periph_run     = 1'b1;
            gi.sys_divided = 1'b1;
         end
         pdm_pkg::MODE_SUBACTIVE: begin
            cpu_run        = 1'b1; // see [RULE4]
            periph_run     = 1'b1;
            gi.use_sub     = 1'b1;
            gi.sub_divided = 1'b1;
         end
         pdm_pkg::MODE_SLEEP_HIGH: periph_run = 1'b1; // see [RULE3]
         pdm_pkg::MODE_SLEEP_MED: begin
            periph_run     = 1'b1; // see [RULE3]
            gi.sys_divided = 1'b1;
         end
         pdm_pkg::MODE_SUBSLEEP: begin
            periph_run     = 1'b1; // see [RULE5]
            gi.use_sub     = 1'b1;
            gi.sub_divided = 1'b1;
         end
         pdm_pkg::MODE_WATCH: begin
            periph_run = 1'b1; // see [RULE5]
            gi.use_sub = 1'b1;
         end
         pdm_pkg::MODE_STANDBY: periph_run = 1'b0; // see [RULE6]
         default: periph_run = 1'b0;
      endcase
      if (waiting_ff) begin
         cpu_run    = 1'b0;
         periph_run = 1'b0;
      end
   end

   assign gi.sys_div_sel = ctrl_one_ff[`PDM_BIT_MED_DIV_HI:`PDM_BIT_MED_DIV_LO];
   assign gi.sub_div_sel = ctrl_one_ff[`PDM_BIT_MED_DIV_HI:`PDM_BIT_MED_DIV_LO];
   assign gi.sub_tick    = sub_tick;

   // Prescaler counts system ticks; cleared while the system clock generator is stopped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prescale_ff <= 13'h0000;
      end else if (stopped_osc || waiting_ff) begin
         prescale_ff <= 13'h0000; // see [RULE17]
      end else if (gi.sys_tick) begin
         prescale_ff <= prescale_ff + 13'h0001;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_halt
         assign halt_mask[i] = gi.clk_tick && !halt_ff[i]; // see [RULE7]
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PDM_ADDR_CTRL_ONE: rdata_ff <= ctrl_one_ff;
            `PDM_ADDR_CTRL_TWO: rdata_ff <= ctrl_two_ff;
            `PDM_ADDR_HALT:     rdata_ff <= halt_ff;
            `PDM_ADDR_STATUS:   rdata_ff <= mode_ff;
            `PDM_ADDR_WAKE:     rdata_ff <= {7'h00, waiting_ff};
            default:            rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign reg_rdata     = rdata_ff;
   assign cpu_clk_en    = cpu_run && gi.clk_tick;
   assign periph_clk_en = halt_mask;
   assign osc_run       = !stopped_osc || waiting_ff;
   assign prescale_out  = prescale_ff;
   assign mode_out      = mode_ff;
endmodule : power_down_mode_controller

// file: pdm_defines.svh
// Constants of the power-down mode controller: register offsets, field positions, reset values, wait counts.
// Included by bare name; definitions only.
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
`define PDM_ADDR_CTRL_ONE      4'h0
`define PDM_ADDR_CTRL_TWO      4'h1
`define PDM_ADDR_HALT          4'h2
`define PDM_ADDR_STATUS        4'h3
`define PDM_ADDR_SLEEP         4'h4
`define PDM_ADDR_WAKE          4'h5
`define PDM_CTRL_ONE_RESET     8'h03
`define PDM_CTRL_TWO_RESET     8'h00
`define PDM_HALT_RESET         8'h00
`define PDM_BIT_DEEP_STOP      7
`define PDM_BIT_WAIT_HI        6
`define PDM_BIT_WAIT_LO        4
`define PDM_BIT_SLOW_ON_WAKE   3
`define PDM_BIT_SLEEP_TARGET   2
`define PDM_BIT_MED_DIV_HI     1
`define PDM_BIT_MED_DIV_LO     0
`define PDM_BIT_DIRECT_XFER    1
`define PDM_BIT_MEDIUM_SPEED   0
`define PDM_WAIT_000           15'h2000
`define PDM_WAIT_001           15'h4000
`define PDM_WAIT_010           15'h0400
`define PDM_WAIT_011           15'h0800
`define PDM_WAIT_100           15'h1000
`define PDM_WAIT_101           15'h0002
`define PDM_WAIT_110           15'h0008
`define PDM_WAIT_111           15'h0010
`define PDM_PRESCALE_W         13
`endif

// file: pdm_pkg.sv
// Types of the power-down mode controller.
// Needs nothing beyond the language.
package pdm_pkg;
   typedef enum logic [7:0] {
      MODE_ACTIVE_HIGH = 8'h01,
      MODE_ACTIVE_MED  = 8'h02,
      MODE_SUBACTIVE   = 8'h04,
      MODE_SLEEP_HIGH  = 8'h08,
      MODE_SLEEP_MED   = 8'h10,
      MODE_SUBSLEEP    = 8'h20,
      MODE_WATCH       = 8'h40,
      MODE_STANDBY     = 8'h80
   } mode_t;
endpackage : pdm_pkg

// file: clk_gate_if.sv
// Clock-enable bundle between the mode controller and its divider.
// Both ends sit on clk_sys.
`timescale 1ns/100ps
interface clk_gate_if;
   logic       use_sub;
   logic [1:0] sys_div_sel;
   logic [1:0] sub_div_sel;
   logic       sys_divided;
   logic       sub_divided;
   logic       sub_tick;
   logic       sys_tick;
   logic       clk_tick;
   modport ctrl (output use_sub, output sys_div_sel, output sub_div_sel, output sys_divided,
                 output sub_divided, input sub_tick, input sys_tick, input clk_tick);
   modport div  (input use_sub, input sys_div_sel, input sub_div_sel, input sys_divided,
                 input sub_divided, input sub_tick, output sys_tick, output clk_tick);
endinterface : clk_gate_if

// file: clk_divider.sv
// Divided clock-enable generator for system clock and subclock.
// Subclock arrives as a one-cycle tick synchronous to clk_sys.
`timescale 1ns/100ps
module clk_divider (
   input  wire logic   clk_sys,
   input  wire logic   rst_n,
   input  wire logic   run,
   clk_gate_if.div     gi
);
   logic [5:0] sys_cnt_ff;
   logic [2:0] sub_cnt_ff;
   logic       sys_hit;
   logic       sub_hit;

   // Medium speed: osc/8, /16, /32, /64
   always_comb begin
      unique case (gi.sys_div_sel)
         2'b00:   sys_hit = (sys_cnt_ff[2:0] == 3'h7);
         2'b01:   sys_hit = (sys_cnt_ff[3:0] == 4'hf);
         2'b10:   sys_hit = (sys_cnt_ff[4:0] == 5'h1f);
         default: sys_hit = (sys_cnt_ff == 6'h3f);
      endcase
   end

   // Subclock: w/2, /4, /8
   always_comb begin
      unique case (gi.sub_div_sel)
         2'b00:   sub_hit = gi.sub_tick && sub_cnt_ff[0];
         2'b01:   sub_hit = gi.sub_tick && (sub_cnt_ff[1:0] == 2'h3);
         default: sub_hit = gi.sub_tick && (sub_cnt_ff == 3'h7);
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sys_cnt_ff <= 6'h00;
      end else if (!run || gi.use_sub) begin
         sys_cnt_ff <= 6'h00;
      end else begin
         sys_cnt_ff <= sys_cnt_ff + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt_ff <= 3'h0;
      end else if (!run || !gi.use_sub) begin
         sub_cnt_ff <= 3'h0;
      end else if (gi.sub_tick) begin
         sub_cnt_ff <= sub_cnt_ff + 3'h1;
      end
   end

   always_comb begin
      gi.sys_tick = run && !gi.use_sub && (gi.sys_divided ? sys_hit : 1'b1);
      if (!run) begin
         gi.clk_tick = 1'b0;
      end else if (gi.use_sub) begin
         gi.clk_tick = gi.sub_divided ? sub_hit : gi.sub_tick;
      end else begin
         gi.clk_tick = gi.sys_tick;
      end
   end
endmodule : clk_divider

// file: cpu_core_model.sv
// CPU core model: one-cycle sleep and wake pulses on request, and a free subclock tick.
// Runs on clk_sys; the tick comes once every four system cycles.
`timescale 1ns/100ps
module cpu_core_model (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   output logic      sleep_req,
   output logic      wake_irq,
   output logic      sub_tick
);
   logic [1:0] sub_cnt_ff;
   initial begin
      sleep_req = 1'b0;
      wake_irq = 1'b0;
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt_ff <= 2'h0;
      end else begin
         sub_cnt_ff <= sub_cnt_ff + 2'h1;
      end
   end
   assign sub_tick = (sub_cnt_ff == 2'h3);
   // Sleep instruction or wake interrupt, held over exactly one rising edge
   task pulse(input logic slp);
      if (slp) sleep_req <= 1'b1;
      else wake_irq <= 1'b1;
      @(posedge clk_sys);
      #1;
      if (slp) sleep_req <= 1'b0;
      else wake_irq <= 1'b0;
   endtask : pulse
endmodule : cpu_core_model

// file: power_down_mode_controller_asserts.sv
// Checker of the power-down mode controller: mode gating, wake wait and clock rates.
// Bound to the top module; assumes a subclock tick no faster than one in four cycles.
`timescale 1ns/100ps
module power_down_mode_controller_checker (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        sleep_req,
   input  wire logic        wake_irq,
   input  wire logic        cpu_clk_en,
   input  wire logic [7:0]  periph_clk_en,
   input  wire logic        osc_run,
   input  wire logic [12:0] prescale_out,
   input  wire logic [7:0]  mode_out
);
   logic [15:0] wait_cnt_ff;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // Cycles since a wake was taken in standby or watch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt_ff <= 16'h0000;
      end else if (mode_out != 8'h80 && mode_out != 8'h40) begin
         wait_cnt_ff <= 16'h0000;
      end else if (wake_irq || wait_cnt_ff != 16'h0000) begin
         wait_cnt_ff <= wait_cnt_ff + 16'h0001;
      end
   end
   sequence stop_wake_s;
      wake_irq && !sleep_req && mode_out == 8'h80 && wait_cnt_ff == 16'h0000;
   endsequence
   sequence held_s;
      (mode_out == 8'h80 && !cpu_clk_en && periph_clk_en == 8'h00) [*2];
   endsequence
   active_run_a: assert property (mode_out == 8'h01 |-> cpu_clk_en && osc_run)
      else $error("active mode without clocks");
   stop_gate_a: assert property (mode_out == 8'h80 |-> !cpu_clk_en && periph_clk_en == 8'h00)
      else $error("standby with clocks running");
   sleep_halt_a: assert property (mode_out inside {8'h08, 8'h10, 8'h20, 8'h40} |-> !cpu_clk_en)
      else $error("cpu clocked in a sleep mode");
   presc_clear_a: assert property (mode_out inside {8'h80, 8'h40, 8'h04, 8'h20} && wait_cnt_ff == 16'h0000
      && $past(mode_out) inside {8'h80, 8'h40, 8'h04, 8'h20} |-> prescale_out == 13'h0000)
      else $error("prescaler not cleared");
   sleep_wake_a: assert property (wake_irq && !sleep_req && mode_out inside {8'h08, 8'h10}
      |=> mode_out inside {8'h01, 8'h02})
      else $error("sleep not left on wake");
   wake_hold_a: assert property (stop_wake_s |=> held_s)
      else $error("clocks released before wake wait");
   wake_bound_a: assert property (wait_cnt_ff <= 16'h4001)
      else $error("wake wait too long");
   med_rate_a: assert property (mode_out == 8'h02 && cpu_clk_en
      |=> (!cpu_clk_en || mode_out == 8'h01) [*7])
      else $error("medium clock faster than one in eight");
   sub_rate_a: assert property (mode_out == 8'h04 && cpu_clk_en
      |=> (!cpu_clk_en || mode_out == 8'h01) [*7])
      else $error("subactive clock faster than tick by two");
endmodule : power_down_mode_controller_checker
bind power_down_mode_controller power_down_mode_controller_checker power_down_mode_controller_checker_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .sleep_req(sleep_req), .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en),
   .periph_clk_en(periph_clk_en), .osc_run(osc_run), .prescale_out(prescale_out), .mode_out(mode_out));

// file: power_down_mode_controller_test.sv
// Testbench of the power-down mode controller: registers, sleep modes, clock rates, wake waits.
// Drives the register port itself; the CPU model gives sleep, wake and subclock ticks.
`timescale 1ns/100ps
`include "pdm_defines.svh"
module power_down_mode_controller_test;
   logic        clk_sys;
   logic        rst_n;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        sleep_req;
   logic        wake_irq;
   logic        sub_tick;
   logic        cpu_clk_en;
   logic [7:0]  periph_clk_en;
   logic        osc_run;
   logic [12:0] prescale_out;
   logic [7:0]  mode_out;
   logic        rd_d = 1'b0;
   logic [7:0]  halt_v;
   logic [7:0]  exp_q[$];
   logic [14:0] waits [8] = '{`PDM_WAIT_000, `PDM_WAIT_001, `PDM_WAIT_010, `PDM_WAIT_011,
                               `PDM_WAIT_100, `PDM_WAIT_101, `PDM_WAIT_110, `PDM_WAIT_111};
   logic [7:0]  tab [5][3] = '{'{8'h03, 8'h00, 8'h08}, '{8'h03, 8'h01, 8'h10}, '{8'h0b, 8'h00, 8'h20},
                                '{8'h87, 8'h00, 8'h40}, '{8'hd3, 8'h00, 8'h80}};
   int          error_cnt = 0;
   int          tests_run = 0;
   int          seed = 32'h884a;
   int          c;
   power_down_mode_controller power_down_mode_controller_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req), .wake_irq(wake_irq), .sub_tick(sub_tick),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run), .prescale_out(prescale_out),
      .mode_out(mode_out));
   cpu_core_model cpu_core_model_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .sleep_req(sleep_req), .wake_irq(wake_irq), .sub_tick(sub_tick));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick;
      reg_wr <= 1'b0;
      tick;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick;
      reg_rd <= 1'b0;
      tick;
   endtask : rd
   // Read data stand only in the cycle after the strobe
   always @(posedge clk_sys) rd_d <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_d === 1'b1) begin
         if (exp_q.size() == 0) chk(16'h1, 16'h0);
         else chk(reg_rdata, exp_q.pop_front());
      end
   end
   task wait_chg(input logic [7:0] m, output int n);
      n = 0;
      while (mode_out === m && n < 20000) begin
         tick;
         n++;
      end
      if (n >= 20000) begin
         error_cnt++;
         results;
      end
   endtask : wait_chg
   // Back to active high speed by wake or by a direct-transfer sleep
   task back_home;
      logic [7:0] m;
      int         n;
      wr(`PDM_ADDR_CTRL_ONE, 8'hd3);
      wr(`PDM_ADDR_CTRL_TWO, 8'h02);
      for (int k = 0; k < 3; k++) begin
         m = mode_out;
         if (m !== 8'h01) begin
            cpu_core_model_i.pulse(m === 8'h02 || m === 8'h04);
            wait_chg(m, n);
         end
      end
      chk(mode_out, 8'h01);
   endtask : back_home
   task count_en(output int k);
      k = 0;
      repeat (128) begin
         tick;
         if (cpu_clk_en === 1'b1) k++;
      end
   endtask : count_en
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_n <= 1'b1;
      chk(mode_out, 8'h01);
      chk({cpu_clk_en, osc_run, periph_clk_en}, 10'h3ff);
      rd(`PDM_ADDR_CTRL_ONE, `PDM_CTRL_ONE_RESET);
      rd(4'h4, 8'h00);
      halt_v = 8'($random(seed));
      wr(`PDM_ADDR_HALT, halt_v);
      chk(periph_clk_en, 8'(~halt_v));
      wr(`PDM_ADDR_HALT, 8'h00);
      chk(16'(prescale_out != 13'h0000), 16'h0001);
      $display("reset and halt test done");
      for (int i = 0; i < 5; i++) begin
         wr(`PDM_ADDR_CTRL_ONE, tab[i][0]);
         wr(`PDM_ADDR_CTRL_TWO, tab[i][1]);
         cpu_core_model_i.pulse(1'b1);
         chk(mode_out, tab[i][2]);
         chk(cpu_clk_en, 1'b0);
         tick;
         if (tab[i][2] > 8'h10) chk(prescale_out, 13'h0000);
         if (tab[i][2] == 8'h80) chk({osc_run, periph_clk_en}, 9'h000);
         back_home;
      end
      $display("sleep mode test done");
      wr(`PDM_ADDR_CTRL_ONE, 8'hd0);
      rd(`PDM_ADDR_CTRL_ONE, 8'hd0);
      wr(`PDM_ADDR_CTRL_TWO, 8'h03);
      cpu_core_model_i.pulse(1'b1);
      chk(mode_out, 8'h02);
      count_en(c);
      chk(16'(c), 16'h0010);
      wr(`PDM_ADDR_CTRL_ONE, 8'hd3);
      rd(`PDM_ADDR_CTRL_ONE, 8'hd0);
      back_home;
      wr(`PDM_ADDR_CTRL_ONE, 8'hd8);
      cpu_core_model_i.pulse(1'b1);
      chk(mode_out, 8'h04);
      count_en(c);
      chk(16'(c), 16'h0010);
      back_home;
      $display("clock rate test done");
      // Every wait code, short and long, leaving standby
      for (int i = 0; i < 8; i++) begin
         wr(`PDM_ADDR_CTRL_ONE, {1'b1, 3'(i), 4'h3});
         wr(`PDM_ADDR_CTRL_TWO, 8'h00);
         cpu_core_model_i.pulse(1'b1);
         cpu_core_model_i.pulse(1'b0);
         wait_chg(8'h80, c);
         chk(16'(c), 16'(waits[i]));
         chk(mode_out, 8'h01);
      end
      $display("wake wait test done");
      results;
   end
endmodule : power_down_mode_controller_test
